//--- rtl/mmn_exec.sv
`timescale 1ns/1ps
module mmn_exec (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Instruction feed
  input wire logic [mmn_pkg::IW-1:0] instr_word,
  input wire logic instr_valid,
  output logic instr_take,
  // Data memory
  output logic [mmn_pkg::AW-1:0] mem_addr,
  output logic mem_rd_en,
  output logic mem_wr_en,
  output logic [mmn_pkg::DW-1:0] mem_wdata,
  input wire logic [mmn_pkg::DW-1:0] mem_rdata,
  // Software register port
  input wire logic [mmn_pkg::SW_AW-1:0] sw_addr,
  input wire logic [mmn_pkg::DW-1:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [mmn_pkg::DW-1:0] sw_rdata,
  // Core state
  output logic [mmn_pkg::DW-1:0] acc,
  output logic [mmn_pkg::DW-1:0] bank_select_register,
  output logic [mmn_pkg::DW-1:0] prod_hi,
  output logic [mmn_pkg::DW-1:0] prod_lo,
  output logic [mmn_pkg::ST_W-1:0] status
);
  import mmn_pkg::*;

  // ************************************************************
  // Declarations
  // ************************************************************
  mmn_ph_t phase_reg, phase_next;
  mmn_op_t op_reg, op_dec;
  logic [IW-1:0] instr_reg;
  logic mff_pend_reg;
  logic [DW-1:0] mff_data_reg;
  logic [DW-1:0] acc_reg;
  logic [BSR_W-1:0] bsr_reg;
  logic [DW-1:0] prod_hi_reg;
  logic [DW-1:0] prod_lo_reg;
  logic [ST_W-1:0] status_reg;
  logic ext_en_reg;
  logic [AW-1:0] idx_base_reg;
  logic [AW-1:0] mem_addr_reg;
  logic mem_rd_reg;
  logic mem_wr_reg;
  logic [DW-1:0] mem_wdata_reg;
  logic [15:0] prod_pend_reg;
  logic [ST_W-1:0] flag_pend_reg;
  logic [DW-1:0] sw_rdata_reg;
  logic [DW-1:0] sw_rd_mux;
  logic [AW-1:0] bank_addr_w;
  logic [AW-1:0] addr_next;
  logic [DW-1:0] opnd_w;
  logic [15:0] prod_w;
  logic [DW-1:0] neg_w;
  logic [ST_W-1:0] neg_flags_w;
  logic dec_reads, dec_mff, op_is_mul, op_writes_mem;
  logic at_q1, at_q3, at_q4;

  // ************************************************************
  // Phase sequencing
  // ************************************************************
  // Four phases per instruction cycle, free running from reset
  always_comb begin
    unique case (phase_reg)
      PH_Q1: phase_next = PH_Q2;
      PH_Q2: phase_next = PH_Q3;
      PH_Q3: phase_next = PH_Q4;
      PH_Q4: phase_next = PH_Q1;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      phase_reg <= PH_Q1;
    end else begin
      phase_reg <= phase_next;
    end
  end

  assign at_q1 = (phase_reg == PH_Q1);
  assign at_q3 = (phase_reg == PH_Q3);
  assign at_q4 = (phase_reg == PH_Q4);
  assign instr_take = at_q1;

  // ************************************************************
  // Decode and addressing
  // ************************************************************
  // A missing word runs as a no-op so the phases never stall
  assign op_dec = instr_valid ? mmn_decode(instr_word, mff_pend_reg) : OP_NOP;
  assign dec_mff = (op_dec == OP_MFF1) || (op_dec == OP_MFF2);
  // Destination word of the move does no dummy read
  assign dec_reads = (op_dec == OP_MFF1) || (op_dec == OP_FILEMUL)
                   || (op_dec == OP_NEG);
  assign addr_next = dec_mff ? instr_word[AW-1:0] : bank_addr_w;

  mmn_bank_addr u_addr (
    .file_addr(instr_word[7:0]),
    .bank_sel(instr_word[8]),
    .bank_reg(bsr_reg),
    .ext_en(ext_en_reg),
    .idx_base(idx_base_reg),
    .data_addr(bank_addr_w)
  );

  // ************************************************************
  // Data path
  // ************************************************************
  // Literal multiply takes the low byte, file ops take the read data
  assign opnd_w = (op_reg == OP_LITMUL) ? instr_reg[7:0] : mem_rdata;
  assign op_is_mul = (op_reg == OP_LITMUL) || (op_reg == OP_FILEMUL);
  assign op_writes_mem = (op_reg == OP_STORE) || (op_reg == OP_NEG)
                       || (op_reg == OP_MFF2);

  mmn_alu u_alu (
    .acc(acc_reg),
    .opnd(opnd_w),
    .product(prod_w),
    .neg_result(neg_w),
    .neg_flags(neg_flags_w)
  );

  // Memory strobes: read in the second phase, write in the fourth
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      instr_reg <= 16'h0000;
      op_reg <= OP_NOP;
      mem_addr_reg <= 12'h000;
      mem_rd_reg <= 1'b0;
      mem_wr_reg <= 1'b0;
      mem_wdata_reg <= RST_BYTE;
    end else begin
      unique case (phase_reg)
        PH_Q1: begin
          instr_reg <= instr_word;
          op_reg <= op_dec;
          mem_addr_reg <= addr_next;
          mem_rd_reg <= dec_reads;
        end
        PH_Q2: begin
          mem_rd_reg <= 1'b0;
        end
        PH_Q3: begin
          mem_wr_reg <= op_writes_mem;
          if (op_reg == OP_STORE) begin
            mem_wdata_reg <= acc_reg;
          end else if (op_reg == OP_NEG) begin
            mem_wdata_reg <= neg_w;
          end else begin
            mem_wdata_reg <= mff_data_reg;
          end
        end
        PH_Q4: begin
          mem_wr_reg <= 1'b0;
        end
      endcase
    end
  end

  // Results staged in the third phase, committed in the fourth
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      prod_pend_reg <= 16'h0000;
      flag_pend_reg <= 5'h00;
      mff_data_reg <= RST_BYTE;
      mff_pend_reg <= 1'b0;
    end else begin
      if (at_q3) begin
        prod_pend_reg <= prod_w;
        flag_pend_reg <= neg_flags_w;
        if (op_reg == OP_MFF1) begin
          mff_data_reg <= mem_rdata;
        end
      end
      if (at_q4) begin
        mff_pend_reg <= (op_reg == OP_MFF1);
      end
    end
  end

  // ************************************************************
  // Core and software registers
  // ************************************************************
  // Core commit comes last so it wins over a software write
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      acc_reg <= RST_BYTE;
      bsr_reg <= 4'h0;
      prod_hi_reg <= RST_BYTE;
      prod_lo_reg <= RST_BYTE;
      status_reg <= 5'h00;
      ext_en_reg <= 1'b0;
      idx_base_reg <= 12'h000;
    end else begin
      if (sw_wr) begin
        unique case (sw_addr)
          REG_ACC: acc_reg <= sw_wdata;
          REG_BSR: bsr_reg <= sw_wdata[BSR_W-1:0];
          REG_PRODUCT_LOW_BYTE: prod_lo_reg <= sw_wdata;
          REG_PRODUCT_HIGH_BYTE: prod_hi_reg <= sw_wdata;
          REG_STATUS: status_reg <= sw_wdata[ST_W-1:0];
          REG_CTRL: ext_en_reg <= sw_wdata[CTRL_EXT];
          REG_IDXL: idx_base_reg[7:0] <= sw_wdata;
          REG_IDXH: idx_base_reg[AW-1:8] <= sw_wdata[AW-9:0];
        endcase
      end
      if (at_q4) begin
        unique case (op_reg)
          OP_LITACC: acc_reg <= instr_reg[7:0];
          OP_BANK: bsr_reg <= instr_reg[BSR_W-1:0];
          OP_LITMUL, OP_FILEMUL: begin
            prod_hi_reg <= prod_pend_reg[15:8];
            prod_lo_reg <= prod_pend_reg[7:0];
          end
          OP_NEG: status_reg <= flag_pend_reg;
          default: ;
        endcase
      end
    end
  end

  // Read mux; upper bank bits are not stored and read zero
  always_comb begin
    unique case (sw_addr)
      REG_ACC: sw_rd_mux = acc_reg;
      REG_BSR: sw_rd_mux = {4'h0, bsr_reg};
      REG_PRODUCT_LOW_BYTE: sw_rd_mux = prod_lo_reg;
      REG_PRODUCT_HIGH_BYTE: sw_rd_mux = prod_hi_reg;
      REG_STATUS: sw_rd_mux = {3'h0, status_reg};
      REG_CTRL: sw_rd_mux = {7'h00, ext_en_reg};
      REG_IDXL: sw_rd_mux = idx_base_reg[7:0];
      REG_IDXH: sw_rd_mux = {4'h0, idx_base_reg[AW-1:8]};
    endcase
  end

  // Read data stands for the one cycle after the strobe only
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sw_rdata_reg <= RST_BYTE;
    end else begin
      sw_rdata_reg <= sw_rd ? sw_rd_mux : RST_BYTE;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign mem_addr = mem_addr_reg;
  assign mem_rd_en = mem_rd_reg;
  assign mem_wr_en = mem_wr_reg;
  assign mem_wdata = mem_wdata_reg;
  assign sw_rdata = sw_rdata_reg;
  assign acc = acc_reg;
  assign bank_select_register = {4'h0, bsr_reg};
  assign prod_hi = prod_hi_reg;
  assign prod_lo = prod_lo_reg;
  assign status = status_reg;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  property p_bsr_hi_zero;
    bank_select_register[7:4] == 4'h0;
  endproperty
  a_bsr_hi_zero: assert property (p_bsr_hi_zero) else $error("bank upper bits set");
  property p_lit_acc;
    (at_q4 && op_reg == OP_LITACC) |=> (acc == $past(instr_reg[7:0])) && $stable(status);
  endproperty
  a_lit_acc: assert property (p_lit_acc) else $error("literal not loaded");
  property p_mul_prod;
    logic [15:0] exp;
    (phase_reg == PH_Q3 && op_is_mul, exp = 16'(acc_reg) * 16'(opnd_w))
      |-> ##2 ({prod_hi, prod_lo} == exp);
  endproperty
  a_mul_prod: assert property (p_mul_prod) else $error("bad product");
  property p_mul_flags;
    (at_q4 && op_is_mul) |=> $stable(status) && $stable(acc);
  endproperty
  a_mul_flags: assert property (p_mul_flags) else $error("multiply changed flags");
  property p_prod_hold;
    !(at_q4 && op_is_mul) && !sw_wr |=> $stable(prod_hi) && $stable(prod_lo);
  endproperty
  a_prod_hold: assert property (p_prod_hold) else $error("product disturbed");
  sequence s_mff_dest_start;
    phase_reg == PH_Q2 && op_reg == OP_MFF2;
  endsequence
  sequence s_mff_dest_write;
    !mem_rd_en ##2 (mem_wr_en && mem_wdata == mff_data_reg);
  endsequence
  property p_mff_dest;
    s_mff_dest_start |-> s_mff_dest_write;
  endproperty
  a_mff_dest: assert property (p_mff_dest) else $error("move destination wrong");
  property p_neg_write;
    logic [7:0] src;
    (at_q3 && op_reg == OP_NEG, src = mem_rdata)
      |=> mem_wr_en && (mem_wdata == 8'(~src + 8'h01)) ##1 !mem_wr_en;
  endproperty
  a_neg_write: assert property (p_neg_write) else $error("negate result wrong");
  property p_neg_flags;
    (at_q4 && op_reg == OP_NEG) |=>
      status[ST_Z] == ($past(mem_wdata) == 8'h00) && status[ST_N] == $past(mem_wdata[7]);
  endproperty
  a_neg_flags: assert property (p_neg_flags) else $error("negate flags wrong");
  property p_access_bank;
    (at_q1 && (op_dec inside {OP_STORE, OP_NEG, OP_FILEMUL}) && !instr_word[8] && !ext_en_reg
      && instr_word[7:0] < ACCESS_SPLIT) |=> mem_addr == {ACCESS_LO_BANK, $past(instr_word[7:0])};
  endproperty
  a_access_bank: assert property (p_access_bank) else $error("access bank wrong");
  property p_indexed;
    (at_q1 && (op_dec inside {OP_STORE, OP_NEG, OP_FILEMUL}) && !instr_word[8] && ext_en_reg
      && instr_word[7:0] <= IDX_LIMIT)
      |=> mem_addr == AW'($past(idx_base_reg) + {4'h0, $past(instr_word[7:0])});
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed address wrong");

endmodule

//--- rtl/mmn_pkg.sv
package mmn_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int DW = 8;
  localparam int AW = 12;
  localparam int IW = 16;
  localparam int ST_W = 5;
  localparam int BSR_W = 4;
  localparam int SW_AW = 3;

  // ************************************************************
  // Opcode patterns
  // ************************************************************
  localparam logic [11:0] OPC_BANK = 12'h010;
  localparam logic [7:0] OPC_LITACC = 8'h0E;
  localparam logic [7:0] OPC_LITMUL = 8'h0D;
  localparam logic [6:0] OPC_STORE = 7'h37;
  localparam logic [6:0] OPC_NEG = 7'h36;
  localparam logic [6:0] OPC_FILEMUL = 7'h01;
  localparam logic [3:0] OPC_MFF1 = 4'hC;
  localparam logic [3:0] OPC_MFF2 = 4'hF;

  // ************************************************************
  // Addressing
  // ************************************************************
  localparam logic [7:0] IDX_LIMIT = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;

  // ************************************************************
  // Status bit positions
  // ************************************************************
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_OV = 3;
  localparam int ST_N = 4;
  localparam logic [7:0] NEG_OV_VALUE = 8'h80;

  // ************************************************************
  // Software register indices and fields
  // ************************************************************
  localparam logic [2:0] REG_ACC = 3'h0;
  localparam logic [2:0] REG_BSR = 3'h1;
  localparam logic [2:0] REG_PRODUCT_LOW_BYTE = 3'h2;
  localparam logic [2:0] REG_PRODUCT_HIGH_BYTE = 3'h3;
  localparam logic [2:0] REG_STATUS = 3'h4;
  localparam logic [2:0] REG_CTRL = 3'h5;
  localparam logic [2:0] REG_IDXL = 3'h6;
  localparam logic [2:0] REG_IDXH = 3'h7;
  localparam int CTRL_EXT = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} mmn_ph_t;

  typedef enum logic [3:0] {
    OP_NOP, OP_MFF1, OP_MFF2, OP_BANK, OP_LITACC,
    OP_STORE, OP_LITMUL, OP_FILEMUL, OP_NEG
  } mmn_op_t;

  // Opcode decode; the second move word only counts after a first
  function automatic mmn_op_t mmn_decode(input logic [IW-1:0] w, input logic pend);
    mmn_op_t op;
    op = OP_NOP;
    if (pend) begin
      if (w[15:12] == OPC_MFF2) begin
        op = OP_MFF2;
      end
    end else if (w[15:4] == OPC_BANK) begin
      op = OP_BANK;
    end else if (w[15:8] == OPC_LITACC) begin
      op = OP_LITACC;
    end else if (w[15:8] == OPC_LITMUL) begin
      op = OP_LITMUL;
    end else if (w[15:9] == OPC_STORE) begin
      op = OP_STORE;
    end else if (w[15:9] == OPC_NEG) begin
      op = OP_NEG;
    end else if (w[15:9] == OPC_FILEMUL) begin
      op = OP_FILEMUL;
    end else if (w[15:12] == OPC_MFF1) begin
      op = OP_MFF1;
    end
    return op;
  endfunction

endpackage

//--- rtl/mmn_bank_addr.sv
`timescale 1ns/1ps
module mmn_bank_addr (
  // Instruction fields
  input wire logic [7:0] file_addr,
  input wire logic bank_sel,
  // Banking state
  input wire logic [mmn_pkg::BSR_W-1:0] bank_reg,
  input wire logic ext_en,
  input wire logic [mmn_pkg::AW-1:0] idx_base,
  // Resolved address
  output logic [mmn_pkg::AW-1:0] data_addr
);
  import mmn_pkg::*;

  logic use_idx;
  logic [AW-1:0] access_addr;
  logic [AW-1:0] idx_addr;

  // Access bank: low part from bank 0, upper part from the top bank
  assign access_addr = (file_addr < ACCESS_SPLIT) ? {ACCESS_LO_BANK, file_addr}
                                                  : {ACCESS_HI_BANK, file_addr};
  // Indexed literal offset wraps within the data space
  assign idx_addr = AW'(idx_base + {4'h0, file_addr});
  assign use_idx = !bank_sel && ext_en && (file_addr <= IDX_LIMIT);
  // Set selector picks the banked window; clear picks the indexed address when enabled and f up to 5F, else the access bank
  assign data_addr = bank_sel ? {bank_reg, file_addr}
                   : (use_idx ? idx_addr : access_addr);

endmodule

//--- rtl/mmn_alu.sv
`timescale 1ns/1ps
module mmn_alu (
  // Operands
  input wire logic [7:0] acc,
  input wire logic [7:0] opnd,
  // Results
  output logic [15:0] product,
  output logic [7:0] neg_result,
  output logic [mmn_pkg::ST_W-1:0] neg_flags
);
  import mmn_pkg::*;

  // Unsigned product; full width so no carry can be lost
  assign product = 16'(acc) * 16'(opnd);
  // Two's complement as inverse plus one
  assign neg_result = 8'(~opnd + 8'h01);

  // Flags of 0 - f: no borrow only when f is zero
  assign neg_flags[ST_C] = (opnd == 8'h00);
  assign neg_flags[ST_DC] = (opnd[3:0] == 4'h0);
  assign neg_flags[ST_Z] = (neg_result == 8'h00);
  assign neg_flags[ST_OV] = (opnd == NEG_OV_VALUE);
  assign neg_flags[ST_N] = neg_result[7];

endmodule

//--- sim/mmn_exec_tb.sv
`timescale 1ns/1ps
module mmn_exec_tb;
  import mmn_pkg::*;

  // ************************************************************
  // Signals
  // ************************************************************
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [IW-1:0] instr_word = '0;
  logic instr_valid = 1'b0;
  logic instr_take;
  logic [AW-1:0] mem_addr;
  logic mem_rd_en;
  logic mem_wr_en;
  logic [DW-1:0] mem_wdata;
  logic [DW-1:0] mem_rdata = 8'hA5;
  logic [SW_AW-1:0] sw_addr = '0;
  logic [DW-1:0] sw_wdata = '0;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [DW-1:0] sw_rdata;
  logic [DW-1:0] acc;
  logic [DW-1:0] bank_select_register;
  logic [DW-1:0] prod_hi;
  logic [DW-1:0] prod_lo;
  logic [ST_W-1:0] status;
  int errors = 0;
  int compares = 0;
  logic [7:0] d;
  logic [7:0] negv [4] = '{8'h3A, 8'h00, 8'h80, 8'h01};

  mmn_exec mmn_exec_inst (
    .ref_clk(ref_clk), .nrst(nrst),
    .instr_word(instr_word), .instr_valid(instr_valid), .instr_take(instr_take),
    .mem_addr(mem_addr), .mem_rd_en(mem_rd_en), .mem_wr_en(mem_wr_en),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata(sw_rdata), .acc(acc), .bank_select_register(bank_select_register), .prod_hi(prod_hi),
    .prod_lo(prod_lo), .status(status)
  );

  // Free-running 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Flags of 0 - f: order N, OV, Z, DC, C from top bit down
  function automatic logic [4:0] neg_flags(input logic [7:0] f);
    logic [7:0] r;
    r = ~f + 8'h01;
    return {r[7], f == 8'h80, r == 8'h00, f[3:0] == 4'h0, f == 8'h00};
  endfunction

  task automatic sw_write(input logic [2:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= v;
    @(posedge ref_clk);
    sw_wr <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe, then drops to zero
  task automatic sw_read(input logic [2:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    sw_rd <= 1'b1;
    sw_addr <= a;
    @(posedge ref_clk);
    sw_rd <= 1'b0;
    #1;
    v = sw_rdata;
    @(posedge ref_clk);
    #1;
    check(16'(sw_rdata), 16'h0000);
  endtask

  // Align to the edge that opens Q4, so the next edge opens Q1
  task automatic sync_slot();
    int n;
    n = 0;
    @(negedge ref_clk);
    while (instr_take !== 1'b1 && n < 8) begin
      @(negedge ref_clk);
      n++;
    end
    repeat (3) @(posedge ref_clk);
  endtask

  // One instruction slot; returns at the edge that opens Q4
  task automatic issue(input logic [15:0] w, input logic [7:0] rd, input logic [11:0] ea,
                       input logic er, input logic ew, input logic [7:0] wd);
    @(posedge ref_clk);
    instr_word <= w;
    instr_valid <= 1'b1;
    #1;
    check(16'(instr_take), 16'h0001);
    @(posedge ref_clk);
    #1;
    check(16'(mem_rd_en), 16'(er));
    if (er || ew) check(16'(mem_addr), 16'(ea));
    @(posedge ref_clk);
    mem_rdata <= rd;
    @(posedge ref_clk);
    // Read data is gone after Q3; show its inverse, not a stale copy
    mem_rdata <= ~rd;
    #1;
    check(16'(mem_wr_en), 16'(ew));
    if (ew) check(16'(mem_wdata), 16'(wd));
  endtask

  // Let the last commit land, then idle one slot to stay aligned
  task automatic fin();
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  // ************************************************************
  // Watchdog
  // ************************************************************
  initial begin
    #100000;
    errors++;
    tally_and_finish();
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    sw_write(REG_IDXL, 8'h20);
    sw_write(REG_IDXH, 8'h03);
    sw_write(REG_BSR, 8'hFF);
    sw_read(REG_BSR, d);
    check(16'(d), 16'h000F);
    sync_slot();
    issue(16'h0107, 8'h11, 12'h000, 1'b0, 1'b0, 8'h00);
    issue(16'h0E5A, 8'h22, 12'h000, 1'b0, 1'b0, 8'h00);
    fin();
    check(16'(bank_select_register), 16'h0007);
    check(16'(acc), 16'h005A);
    check(16'(status), 16'h0000);
    // Banked, access-low and access-high addressing, back to back
    issue(16'h0102, 8'h00, 12'h000, 1'b0, 1'b0, 8'h00);
    issue(16'h6F10, 8'h00, 12'h210, 1'b0, 1'b1, 8'h5A);
    issue(16'h6FFF, 8'h00, 12'h2FF, 1'b0, 1'b1, 8'h5A);
    issue(16'h6E10, 8'h00, 12'h010, 1'b0, 1'b1, 8'h5A);
    issue(16'h6E80, 8'h00, 12'hF80, 1'b0, 1'b1, 8'h5A);
    fin();
    check(16'(status), 16'h0000);
    // Indexed offset only for a clear selector and f up to 5F
    sw_write(REG_CTRL, 8'h01);
    sync_slot();
    issue(16'h6E5F, 8'h00, 12'h37F, 1'b0, 1'b1, 8'h5A);
    issue(16'h6E60, 8'h00, 12'hF60, 1'b0, 1'b1, 8'h5A);
    issue(16'h6F5F, 8'h00, 12'h25F, 1'b0, 1'b1, 8'h5A);
    fin();
    sw_write(REG_CTRL, 8'h00);
    sync_slot();
    // Negate across zero, the most negative value and ordinary ones
    for (int i = 0; i < 4; i++) begin
      issue(16'h6D10, negv[i], 12'h210, 1'b1, 1'b1, ~negv[i] + 8'h01);
      fin();
      check(16'(status), 16'(neg_flags(negv[i])));
      check({prod_hi, prod_lo}, 16'h0000);
    end
    // Multiplies must keep the flags left by the last negate
    issue(16'h0EE2, 8'h00, 12'h000, 1'b0, 1'b0, 8'h00);
    issue(16'h0DC4, 8'h00, 12'h000, 1'b0, 1'b0, 8'h00);
    fin();
    check({prod_hi, prod_lo}, 16'hAD08);
    check(16'(acc), 16'h00E2);
    check(16'(status), 16'h0010);
    issue(16'h0EC4, 8'h00, 12'h000, 1'b0, 1'b0, 8'h00);
    issue(16'h0310, 8'hB5, 12'h210, 1'b1, 1'b0, 8'h00);
    fin();
    check({prod_hi, prod_lo}, 16'h8A94);
    check(16'(acc), 16'h00C4);
    check(16'(status), 16'h0010);
    issue(16'h0D00, 8'h00, 12'h000, 1'b0, 1'b0, 8'h00);
    fin();
    check({prod_hi, prod_lo}, 16'h0000);
    check(16'(status), 16'h0010);
    // Two-word move: read in the first slot, write without read in the second
    issue(16'hC123, 8'h33, 12'h123, 1'b1, 1'b0, 8'h00);
    issue(16'hF456, 8'h77, 12'h456, 1'b0, 1'b1, 8'h33);
    fin();
    check(16'(acc), 16'h00C4);
    check({prod_hi, prod_lo}, 16'h0000);
    tally_and_finish();
  end

endmodule
